//--- testbench/i2mt_slave_model.sv
// Behavioural slave receiver and rival master on the two-wire bus
`timescale 1ns/1ps
`default_nettype none
module i2mt_slave_model (
    // Wire levels
    input  wire logic scl,
    input  wire logic sda,
    // Behaviour knobs
    input  wire logic ack_en,
    input  wire logic arb,
    input  wire logic hog,
    input  wire logic stretch,
    // Pull-down enables
    output logic      s_scl_oe,
    output wire logic s_sda_oe
);
    logic [7:0] sh;
    logic       ack_drv;
    logic       arb_drv;
    int         nb;
    int         n_stop;
    logic [7:0] got_q[$];
    initial begin
        s_scl_oe = 1'b0;
        ack_drv = 1'b0;
        arb_drv = 1'b0;
        nb = 0;
        n_stop = 0;
    end
    // Released lines float high through the pull-ups
    assign s_sda_oe = ack_drv | (arb_drv & arb) | hog;
    // START restarts the bit count, STOP is counted for the bench
    always @(negedge sda) if (scl) nb = 0;
    always @(posedge sda) if (scl) n_stop++;
    // Sample on the rising clock, MSB first, byte complete after eight
    always @(posedge scl) begin
        sh = {sh[6:0], sda};
        nb++;
        if (nb == 8) got_q.push_back(sh);
    end
    // Change only with clock low; stretch models a slow receiver
    always @(negedge scl) begin
        if (nb >= 9) nb = 0;
        ack_drv = ack_en && nb == 8;
        arb_drv = nb < 8;
        if (stretch && nb == 0) begin
            s_scl_oe = 1'b1;
            #200 s_scl_oe = 1'b0;
        end
    end
endmodule // i2mt_slave_model
`default_nettype wire

//--- testbench/i2mt_top_sva.sv
// Concurrent checks on the transmit sequencer's register bus and serial pins
`timescale 1ns/1ps
`default_nettype none
module i2mt_top_sva (
    // Clock and reset
    input wire logic        clk_sys,
    input wire logic        rst,
    // Register bus
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic        wb_we_i,
    input wire logic [7:0]  wb_adr_i,
    input wire logic [3:0]  wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic        wb_ack_o,
    // Serial pins
    input wire logic        scl_i,
    input wire logic        scl_o,
    input wire logic        scl_oe,
    input wire logic        sda_i,
    input wire logic        sda_o,
    input wire logic        sda_oe
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);
    logic       ext_busy_ff;
    logic [3:0] bit_cnt_ff;
    // Foreign START: data fell with clock high while we were not pulling it
    always @(posedge clk_sys or posedge rst) begin
        if (rst)
            ext_busy_ff <= 1'b0;
        else if ($fell(sda_i) && scl_i && !sda_oe)
            ext_busy_ff <= 1'b1;
        else if ($rose(sda_i) && scl_i)
            ext_busy_ff <= 1'b0;
    end
    // Clock releases since our START; the count lags one edge behind the pin
    always @(posedge clk_sys or posedge rst) begin
        if (rst)
            bit_cnt_ff <= 4'h0;
        else if ($rose(sda_oe) && scl_i)
            bit_cnt_ff <= 4'h0;
        else if ($fell(scl_oe))
            bit_cnt_ff <= (bit_cnt_ff == 4'h9) ? 4'h1 : bit_cnt_ff + 4'h1;
    end
    start_bus_free_a: assert property (
        $rose(sda_oe) && scl_i && !scl_oe |-> !ext_busy_ff)
        else $error("START driven while another master held the bus");
    start_shape_a: assert property (
        $rose(sda_oe) && scl_i && !scl_oe |-> ##[1:400] scl_oe)
        else $error("clock not pulled after START");
    stop_gap_a: assert property ($fell(sda_oe) && scl_i && !scl_oe |=> !sda_oe [*2])
        else $error("data pulled too soon after STOP");
    ack_slot_a: assert property (
        $fell(scl_oe) && bit_cnt_ff == 4'h8 |-> !sda_oe [*2])
        else $error("data not released in acknowledge slot");
    ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("bus acknowledge longer than one cycle");
    ack_cause_a: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
        else $error("bus acknowledge without request");
    stat_rsvd_a: assert property (
        wb_ack_o && !wb_we_i && wb_adr_i == 8'h04 |-> !wb_dat_o[2])
        else $error("status reserved bit set");
    od_low_a: assert property (scl_o == 1'b0 && sda_o == 1'b0)
        else $error("open drain output not low");
endmodule // i2mt_top_sva
bind i2mt_top i2mt_top_sva u_i2mt_top_sva (
    .clk_sys(clk_sys), .rst(rst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .scl_i(scl_i), .scl_o(scl_o),
    .scl_oe(scl_oe), .sda_i(sda_i), .sda_o(sda_o), .sda_oe(sda_oe)
);
`default_nettype wire

//--- testbench/tb_i2mt_top.sv
// Self-checking bench: register bus master, bus model and scenario sequence
`timescale 1ns/1ps
`default_nettype none
`include "i2mt_map.vh"
module tb_i2mt_top;
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    logic cyc = 1'b0;
    logic stb = 1'b0;
    logic we = 1'b0;
    logic ack_en = 1'b1;
    logic arb = 1'b0;
    logic hog = 1'b0;
    logic stretch = 1'b0;
    logic [7:0] adr = 8'h00;
    logic [31:0] dat = 32'h0;
    logic [7:0] rd;
    bit adr_ph;
    int n_errors = 0;
    int n_compared = 0;
    int n0;
    wire [31:0] dat_o;
    wire ack_o, scl_o, scl_oe, sda_o, sda_oe, s_scl_oe, s_sda_oe;
    // Pull-ups: a wire is low while any party pulls it
    wire scl = !(scl_oe | s_scl_oe);
    wire sda = !(sda_oe | s_sda_oe);
    logic [7:0] ra[5] = '{`I2MT_OFF_CTRL, `I2MT_OFF_STAT, `I2MT_OFF_DATA, `I2MT_OFF_RATE, 8'h14};
    logic [7:0] rv[5] = '{`I2MT_CTRL_RST, `I2MT_ST_NONE, `I2MT_DATA_RST, `I2MT_RATE_RST, 8'h00};
    i2mt_top u_i2mt_top (
        .clk_sys(clk_sys), .rst(rst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(dat), .wb_dat_o(dat_o), .wb_ack_o(ack_o),
        .scl_i(scl), .scl_o(scl_o), .scl_oe(scl_oe), .sda_i(sda), .sda_o(sda_o), .sda_oe(sda_oe)
    );
    i2mt_slave_model u_i2mt_slave_model (
        .scl(scl), .sda(sda), .ack_en(ack_en), .arb(arb), .hog(hog), .stretch(stretch),
        .s_scl_oe(s_scl_oe), .s_sda_oe(s_sda_oe)
    );
    always #4 clk_sys = ~clk_sys;
    task automatic close_out();
        if (n_errors == 0 && n_compared > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] s);
        n_compared++;
        if (s !== e) begin
            n_errors++;
            $display("MISMATCH %s expected %h seen %h", nm, e, s);
        end
    endtask
    // Classic single cycle: hold everything until ack is sampled high
    task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        dat <= {24'h0, d};
        do @(posedge clk_sys); while (ack_o !== 1'b1);
        rd = dat_o[7:0];
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask
    task automatic wait_flag();
        do wb(1'b0, `I2MT_OFF_CTRL, 8'h00); while (rd[7] !== 1'b1);
    endtask
    // Model of the code that follows a byte
    function automatic logic [7:0] st_of(input logic [7:0] d, input logic ack);
        if (!adr_ph)
            return ack ? `I2MT_ST_D_ACK : `I2MT_ST_D_NAK;
        if (d[0])
            return ack ? `I2MT_ST_AR_ACK : `I2MT_ST_AR_NAK;
        return ack ? `I2MT_ST_AW_ACK : `I2MT_ST_AW_NAK;
    endfunction
    // Command write (none if zero), wait for the flag, compare the code
    task automatic cmd(input logic [7:0] c, input logic [7:0] e);
        if (c != 8'h00) wb(1'b1, `I2MT_OFF_CTRL, c);
        wait_flag();
        adr_ph = 1'b1;
        wb(1'b0, `I2MT_OFF_STAT, 8'h00);
        chk("status", e, rd & 8'hf8);
    endtask
    // Load a byte, clear the flag, compare code and the byte the slave saw
    task automatic send(input logic [7:0] d, input logic ack);
        logic [7:0] e;
        logic [7:0] got;
        e = st_of(d, ack);
        ack_en <= ack;
        wb(1'b1, `I2MT_OFF_DATA, d);
        wb(1'b1, `I2MT_OFF_CTRL, 8'h84);
        wait_flag();
        adr_ph = 1'b0;
        wb(1'b0, `I2MT_OFF_STAT, 8'h00);
        chk("status", e, rd & 8'hf8);
        got = u_i2mt_slave_model.got_q.pop_front();
        chk("byte", d, got);
    endtask
    // Cut a hang short
    initial begin
        #400000;
        n_errors++;
        close_out();
    end
    initial begin
        void'($urandom(6));
        repeat (3) @(posedge clk_sys);
        rst <= 1'b0;
        foreach (ra[i]) begin
            wb(1'b0, ra[i], 8'h00);
            chk("reset value", rv[i], rd);
        end
        wb(1'b1, `I2MT_OFF_RATE, 8'h01); // Two cycles a quarter: 64 ns serial clock
        // Data write with the flag low is dropped and flagged
        wb(1'b1, `I2MT_OFF_DATA, 8'h5a);
        wb(1'b0, `I2MT_OFF_CTRL, 8'h00);
        chk("collision", 8'h08, rd & 8'h08);
        wb(1'b0, `I2MT_OFF_DATA, 8'h00);
        chk("dropped data", `I2MT_DATA_RST, rd);
        // Another master owns the bus; our START waits for its STOP
        hog <= 1'b1;
        repeat (4) @(posedge clk_sys);
        wb(1'b1, `I2MT_OFF_CTRL, 8'ha4);
        repeat (50) @(posedge clk_sys);
        chk("held off", 8'h00, {7'h0, sda_oe});
        hog <= 1'b0;
        cmd(8'h00, `I2MT_ST_START);
        send({7'($urandom), 1'b0}, 1'b1);
        repeat (40) @(posedge clk_sys);
        chk("clock held", 8'h01, {7'h0, scl_oe});
        // Link view: transmit mode, bus owned and busy
        wb(1'b0, `I2MT_OFF_LINK, 8'h00);
        chk("link after write address", 8'h03, rd);
        stretch <= 1'b1;
        for (int k = 0; k < 3; k++) send(8'($urandom), k < 2);
        stretch <= 1'b0;
        cmd(8'ha4, `I2MT_ST_RSTART);
        send({7'($urandom), 1'b1}, 1'b0);
        wb(1'b0, `I2MT_OFF_LINK, 8'h00);
        chk("link after read address", 8'h07, rd);
        n0 = u_i2mt_slave_model.n_stop;
        wb(1'b1, `I2MT_OFF_CTRL, 8'h94);
        do wb(1'b0, `I2MT_OFF_CTRL, 8'h00); while (rd[4] !== 1'b0);
        chk("flag after stop", 8'h00, rd & 8'h80);
        chk("stop on wire", 8'(n0 + 1), 8'(u_i2mt_slave_model.n_stop));
        cmd(8'ha4, `I2MT_ST_START);
        send({7'($urandom), 1'b0}, 1'b0);
        n0 = u_i2mt_slave_model.n_stop;
        cmd(8'hb4, `I2MT_ST_START);
        chk("stop then start", 8'(n0 + 1), 8'(u_i2mt_slave_model.n_stop));
        wb(1'b0, `I2MT_OFF_CTRL, 8'h00);
        chk("stop bit", 8'h00, rd & 8'h10);
        // Rival pulls ones low: we lose, then let go of the bus
        arb <= 1'b1;
        wb(1'b1, `I2MT_OFF_DATA, {2'b11, 6'($urandom)});
        wb(1'b1, `I2MT_OFF_CTRL, 8'h84);
        cmd(8'h00, `I2MT_ST_ARBL);
        arb <= 1'b0;
        wb(1'b1, `I2MT_OFF_CTRL, 8'h84);
        repeat (20) @(posedge clk_sys);
        wb(1'b0, `I2MT_OFF_STAT, 8'h00);
        chk("released code", `I2MT_ST_NONE, rd & 8'hf8);
        chk("released pins", 8'h00, {6'h0, scl_oe, sda_oe});
        // Lose again; the queued START must wait until the rival lets go
        cmd(8'ha4, `I2MT_ST_START);
        arb <= 1'b1;
        wb(1'b1, `I2MT_OFF_DATA, 8'hff);
        wb(1'b1, `I2MT_OFF_CTRL, 8'h84);
        cmd(8'h00, `I2MT_ST_ARBL);
        wb(1'b1, `I2MT_OFF_CTRL, 8'ha4);
        repeat (30) @(posedge clk_sys);
        chk("queued start held", 8'h00, {7'h0, sda_oe});
        arb <= 1'b0;
        cmd(8'h00, `I2MT_ST_START);
        close_out();
    end
endmodule // tb_i2mt_top
`default_nettype wire

//--- verilog/i2mt_map.vh
// Register offsets, control fields, status codes and reset values of the transmit sequencer
`ifndef I2MT_MAP_VH
`define I2MT_MAP_VH
// Byte offsets on the register bus
`define I2MT_OFF_CTRL  8'h00
`define I2MT_OFF_STAT  8'h04
`define I2MT_OFF_DATA  8'h08
`define I2MT_OFF_RATE  8'h0c
`define I2MT_OFF_LINK  8'h10
// Control register bit positions
`define I2MT_B_FLAG    7
`define I2MT_B_ACKEN   6
`define I2MT_B_STA     5
`define I2MT_B_STO     4
`define I2MT_B_WCOL    3
`define I2MT_B_EN      2
`define I2MT_B_IEN     0
// Status codes, prescaler bits taken as zero
`define I2MT_ST_START  8'h08
`define I2MT_ST_RSTART 8'h10
`define I2MT_ST_AW_ACK 8'h18
`define I2MT_ST_AW_NAK 8'h20
`define I2MT_ST_D_ACK  8'h28
`define I2MT_ST_D_NAK  8'h30
`define I2MT_ST_ARBL   8'h38
`define I2MT_ST_AR_ACK 8'h40
`define I2MT_ST_AR_NAK 8'h48
`define I2MT_ST_NONE   8'hf8
// Reset values
`define I2MT_CTRL_RST  8'h00
`define I2MT_DATA_RST  8'hff
`define I2MT_PRE_RST   2'h0
`define I2MT_RATE_RST  8'h4d
`endif

//--- verilog/i2mt_sync.v
// Two-stage synchroniser for the serial clock and data pins
`timescale 1ns/1ps
`default_nettype none
module i2mt_sync #(
    parameter W = 2
) (
    // Clock and reset
    input  wire         clk_sys,
    input  wire         rst,
    // Raw pins and their synchronised copies
    input  wire [W-1:0] pin_in,
    output wire [W-1:0] pin_sync
);
    reg [W-1:0] meta_ff;
    reg [W-1:0] sync_ff;

    // One pair of flops per pin; released bus reads high after reset
    genvar i;
    generate
        for (i = 0; i < W; i = i + 1) begin : g_bit
            always @(posedge clk_sys or posedge rst) begin
                if (rst) begin
                    meta_ff[i] <= 1'b1;
                    sync_ff[i] <= 1'b1;
                end else begin
                    meta_ff[i] <= pin_in[i];
                    sync_ff[i] <= meta_ff[i];
                end
            end
        end
    endgenerate

    assign pin_sync = sync_ff;
endmodule // i2mt_sync
`default_nettype wire

//--- verilog/i2mt_tick.v
// Quarter-bit tick generator for the serial clock
`timescale 1ns/1ps
`default_nettype none
module i2mt_tick #(
    parameter W = 10
) (
    // Clock and reset
    input  wire         clk_sys,
    input  wire         rst,
    // Run enable and period (limit + 1 cycles)
    input  wire         run,
    input  wire [W-1:0] limit,
    output reg          tick_ff
);
    reg [W-1:0] cnt_ff;

    // Counter restarts whenever the engine is idle, so a sequence starts on a full quarter
    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            cnt_ff  <= {W{1'b0}};
            tick_ff <= 1'b0;
        end else if (!run) begin
            cnt_ff  <= {W{1'b0}};
            tick_ff <= 1'b0;
        end else if (cnt_ff >= limit) begin
            cnt_ff  <= {W{1'b0}};
            tick_ff <= 1'b1;
        end else begin
            cnt_ff  <= cnt_ff + {{(W-1){1'b0}}, 1'b1};
            tick_ff <= 1'b0;
        end
    end
endmodule // i2mt_tick
`default_nettype wire

//--- verilog/i2mt_top.v
// Two-wire master transmit sequencer with classic Wishbone register slave
//
// Local design decisions: the Wishbone interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "i2mt_map.vh"
module i2mt_top #(
    parameter RATE_W = 8
) (
    // Clock and reset
    input  wire        clk_sys,
    input  wire        rst,
    // Wishbone classic slave
    input  wire        wb_cyc_i,
    input  wire        wb_stb_i,
    input  wire        wb_we_i,
    input  wire [7:0]  wb_adr_i,
    input  wire [3:0]  wb_sel_i,
    input  wire [31:0] wb_dat_i,
    output reg  [31:0] wb_dat_o,
    output reg         wb_ack_o,
    // Open-drain serial clock
    input  wire        scl_i,
    output reg         scl_o,
    output reg         scl_oe,
    // Open-drain serial data
    input  wire        sda_i,
    output reg         sda_o,
    output reg         sda_oe
);
    // Engine states
    localparam [2:0] S_IDLE  = 3'd0;
    localparam [2:0] S_WFREE = 3'd1;
    localparam [2:0] S_START = 3'd2;
    localparam [2:0] S_BIT   = 3'd3;
    localparam [2:0] S_ACK   = 3'd4;
    localparam [2:0] S_HOLD  = 3'd5;
    localparam [2:0] S_STOP  = 3'd6;

    // Address decode shared by read and write paths
    function hit;
        input [7:0] adr;
        input [7:0] off;
        begin
            hit = (adr == off);
        end
    endfunction

    // Software-visible registers
    reg              flag_ff;
    reg              acken_ff;
    reg              sta_ff;
    reg              sto_ff;
    reg              wcol_ff;
    reg              en_ff;
    reg              ien_ff;
    reg [7:0]        data_ff;
    reg [1:0]        presc_ff;
    reg [RATE_W-1:0] rate_ff;
    // Engine state
    reg [2:0]        state_ff;
    reg [1:0]        phase_ff;
    reg [2:0]        bitn_ff;
    reg [7:0]        shift_ff;
    reg [7:0]        code_ff;
    reg              addr_ff;
    reg              ackok_ff;
    reg              owned_ff;
    reg              rx_mode_ff;
    reg              scl_pull_ff;
    reg              sda_pull_ff;
    // Bus monitor
    reg              scl_p_ff;
    reg              sda_p_ff;
    reg              busy_ff;
    // Next values
    reg [2:0]        nxt_state;
    reg [1:0]        nxt_phase;
    reg [2:0]        nxt_bitn;
    reg [7:0]        nxt_shift;
    reg [7:0]        nxt_code;
    reg              nxt_addr;
    reg              nxt_ackok;
    reg              nxt_owned;
    reg              nxt_rx_mode;
    reg              nxt_scl_pull;
    reg              nxt_sda_pull;
    reg              ev_set;
    reg              ev_sto_clr;

    wire [1:0] pin_sync;
    wire       scl_s = pin_sync[1];
    wire       sda_s = pin_sync[0];
    wire       tick;

    i2mt_sync #(.W(2)) u_sync (
        .clk_sys  (clk_sys),
        .rst      (rst),
        .pin_in   ({scl_i, sda_i}),
        .pin_sync (pin_sync)
    );

    i2mt_tick #(.W(RATE_W + 2)) u_tick (
        .clk_sys (clk_sys),
        .rst     (rst),
        .run     (state_ff != S_IDLE),
        .limit   ({presc_ff, rate_ff}),
        .tick_ff (tick)
    );

    // Bus access decode; write lands on the edge that raises ack
    wire req     = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    wire wr      = req & wb_we_i & wb_sel_i[0];
    wire wr_ctrl = wr & hit(wb_adr_i, `I2MT_OFF_CTRL);
    wire wr_data = wr & hit(wb_adr_i, `I2MT_OFF_DATA);
    wire wr_stat = wr & hit(wb_adr_i, `I2MT_OFF_STAT);
    wire wr_rate = wr & hit(wb_adr_i, `I2MT_OFF_RATE);
    wire [7:0] wd = wb_dat_i[7:0];

    // Engine steps only while not suspended by the flag
    wire go  = en_ff & ~flag_ff;
    // Quarter two waits for the clock line really high, honouring stretching
    wire adv = tick & ~((phase_ff == 2'd2) & ~scl_s);

    // Bus free/busy from START and STOP seen on the wires
    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            scl_p_ff <= 1'b1;
            sda_p_ff <= 1'b1;
            busy_ff  <= 1'b0;
        end else begin
            scl_p_ff <= scl_s;
            sda_p_ff <= sda_s;
            if (scl_s & scl_p_ff & sda_p_ff & ~sda_s)
                busy_ff <= 1'b1;
            else if (scl_s & scl_p_ff & ~sda_p_ff & sda_s)
                busy_ff <= 1'b0;
        end
    end

    // Byte sequencer: quarters 0..3 set data, raise clock, sample, drop clock
    always @* begin
        nxt_state    = state_ff;
        nxt_phase    = phase_ff;
        nxt_bitn     = bitn_ff;
        nxt_shift    = shift_ff;
        nxt_code     = code_ff;
        nxt_addr     = addr_ff;
        nxt_ackok    = ackok_ff;
        nxt_owned    = owned_ff;
        nxt_rx_mode  = rx_mode_ff;
        nxt_scl_pull = scl_pull_ff;
        nxt_sda_pull = sda_pull_ff;
        ev_set       = 1'b0;
        ev_sto_clr   = 1'b0;
        if (!en_ff) begin
            nxt_state    = S_IDLE;
            nxt_owned    = 1'b0;
            nxt_scl_pull = 1'b0;
            nxt_sda_pull = 1'b0;
        end else begin
            case (state_ff)
                S_IDLE: begin
                    nxt_scl_pull = 1'b0;
                    nxt_sda_pull = 1'b0;
                    if (go && sta_ff) begin
                        nxt_state = S_WFREE;
                    end else if (go && code_ff == `I2MT_ST_ARBL) begin
                        nxt_code = `I2MT_ST_NONE;
                    end
                end
                S_WFREE: begin
                    nxt_phase = 2'd0;
                    if (!busy_ff)
                        nxt_state = S_START;
                end
                S_START: if (adv) begin
                    nxt_phase = phase_ff + 2'd1;
                    case (phase_ff)
                        2'd0: nxt_sda_pull = 1'b0;
                        2'd1: nxt_scl_pull = 1'b0;
                        2'd2: nxt_sda_pull = 1'b1;
                        default: begin
                            nxt_scl_pull = 1'b1;
                            nxt_code  = owned_ff ? `I2MT_ST_RSTART
                                                 : `I2MT_ST_START;
                            nxt_owned = 1'b1;
                            ev_set    = 1'b1;
                            nxt_state = S_HOLD;
                        end
                    endcase
                end
                S_HOLD: if (go) begin
                    nxt_phase = 2'd0;
                    nxt_bitn  = 3'd7;
                    if (code_ff == `I2MT_ST_START || code_ff == `I2MT_ST_RSTART) begin
                        nxt_shift   = data_ff;
                        nxt_addr    = 1'b1;
                        nxt_rx_mode = data_ff[0];
                        nxt_state   = S_BIT;
                    end else if (sta_ff && !sto_ff) begin
                        nxt_state = S_START;
                    end else if (sto_ff) begin
                        nxt_state = S_STOP;
                    end else begin
                        nxt_shift = data_ff;
                        nxt_addr  = 1'b0;
                        nxt_state = S_BIT;
                    end
                end
                S_BIT: if (adv) begin
                    nxt_phase = phase_ff + 2'd1;
                    case (phase_ff)
                        2'd0: nxt_sda_pull = ~shift_ff[7];
                        2'd1: nxt_scl_pull = 1'b0;
                        2'd2: if (shift_ff[7] && !sda_s) begin
                            nxt_code     = `I2MT_ST_ARBL;
                            nxt_owned    = 1'b0;
                            nxt_sda_pull = 1'b0;
                            ev_set       = 1'b1;
                            nxt_state    = S_IDLE;
                        end
                        default: begin
                            nxt_scl_pull = 1'b1;
                            nxt_shift    = {shift_ff[6:0], 1'b0};
                            nxt_bitn     = bitn_ff - 3'd1;
                            if (bitn_ff == 3'd0)
                                nxt_state = S_ACK;
                        end
                    endcase
                end
                S_ACK: if (adv) begin
                    nxt_phase = phase_ff + 2'd1;
                    case (phase_ff)
                        2'd0: nxt_sda_pull = 1'b0;
                        2'd1: nxt_scl_pull = 1'b0;
                        2'd2: nxt_ackok = ~sda_s;
                        default: begin
                            nxt_scl_pull = 1'b1;
                            ev_set       = 1'b1;
                            nxt_state    = S_HOLD;
                            if (addr_ff && rx_mode_ff)
                                nxt_code = ackok_ff ? `I2MT_ST_AR_ACK : `I2MT_ST_AR_NAK;
                            else if (addr_ff)
                                nxt_code = ackok_ff ? `I2MT_ST_AW_ACK : `I2MT_ST_AW_NAK;
                            else
                                nxt_code = ackok_ff ? `I2MT_ST_D_ACK : `I2MT_ST_D_NAK;
                        end
                    endcase
                end
                S_STOP: if (adv) begin
                    nxt_phase = phase_ff + 2'd1;
                    case (phase_ff)
                        2'd0: nxt_sda_pull = 1'b1;
                        2'd1: nxt_scl_pull = 1'b0;
                        2'd2: nxt_sda_pull = 1'b0;
                        default: begin
                            ev_sto_clr = 1'b1;
                            nxt_owned  = 1'b0;
                            nxt_code   = `I2MT_ST_NONE;
                            nxt_state  = sta_ff ? S_WFREE : S_IDLE;
                        end
                    endcase
                end
                default: nxt_state = S_IDLE;
            endcase
        end
    end

    // Engine registers
    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            state_ff    <= S_IDLE;
            phase_ff    <= 2'd0;
            bitn_ff     <= 3'd7;
            shift_ff    <= 8'h00;
            code_ff     <= `I2MT_ST_NONE;
            addr_ff     <= 1'b0;
            ackok_ff    <= 1'b0;
            owned_ff    <= 1'b0;
            rx_mode_ff  <= 1'b0;
            scl_pull_ff <= 1'b0;
            sda_pull_ff <= 1'b0;
        end else begin
            state_ff    <= nxt_state;
            phase_ff    <= nxt_phase;
            bitn_ff     <= nxt_bitn;
            shift_ff    <= nxt_shift;
            code_ff     <= nxt_code;
            addr_ff     <= nxt_addr;
            ackok_ff    <= nxt_ackok;
            owned_ff    <= nxt_owned;
            rx_mode_ff  <= nxt_rx_mode;
            scl_pull_ff <= nxt_scl_pull;
            sda_pull_ff <= nxt_sda_pull;
        end
    end

    // Software registers; a hardware flag set beats a same-cycle clear
    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            flag_ff  <= 1'b0;
            acken_ff <= 1'b0;
            sta_ff   <= 1'b0;
            sto_ff   <= 1'b0;
            wcol_ff  <= 1'b0;
            en_ff    <= 1'b0;
            ien_ff   <= 1'b0;
            data_ff  <= `I2MT_DATA_RST;
            presc_ff <= `I2MT_PRE_RST;
            rate_ff  <= `I2MT_RATE_RST;
        end else begin
            if (ev_set)
                flag_ff <= 1'b1;
            else if (wr_ctrl && wd[`I2MT_B_FLAG])
                flag_ff <= 1'b0;
            if (wr_ctrl) begin
                acken_ff <= wd[`I2MT_B_ACKEN];
                sta_ff   <= wd[`I2MT_B_STA];
                sto_ff   <= wd[`I2MT_B_STO];
                en_ff    <= wd[`I2MT_B_EN];
                ien_ff   <= wd[`I2MT_B_IEN];
            end else if (ev_sto_clr) begin
                sto_ff   <= 1'b0;
            end
            // The byte is taken only while the flag is set; a write with the flag low is refused and sets the collision bit
            if (wr_data && flag_ff) begin
                data_ff <= wd;
                wcol_ff <= 1'b0;
            end else if (wr_data) begin
                wcol_ff <= 1'b1;
            end
            if (wr_stat)
                presc_ff <= wd[1:0];
            if (wr_rate)
                rate_ff <= wd[RATE_W-1:0];
        end
    end

    // Bus answer one cycle after the request; unmapped reads return zero
    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end else begin
            wb_ack_o <= req;
            if (req) begin
                if (hit(wb_adr_i, `I2MT_OFF_CTRL))
                    wb_dat_o <= {24'h00_0000, flag_ff, acken_ff, sta_ff, sto_ff,
                                 wcol_ff, en_ff, 1'b0, ien_ff};
                else if (hit(wb_adr_i, `I2MT_OFF_STAT))
                    wb_dat_o <= {24'h00_0000, code_ff[7:3], 1'b0, presc_ff};
                else if (hit(wb_adr_i, `I2MT_OFF_DATA))
                    wb_dat_o <= {24'h00_0000, data_ff};
                else if (hit(wb_adr_i, `I2MT_OFF_RATE))
                    wb_dat_o <= {{(32-RATE_W){1'b0}}, rate_ff};
                else if (hit(wb_adr_i, `I2MT_OFF_LINK))
                    wb_dat_o <= {29'h0000_0000, rx_mode_ff, owned_ff, busy_ff};
                else
                    wb_dat_o <= 32'h0000_0000;
            end
        end
    end

    // Pin drivers: open drain, the wire is only ever pulled low
    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            scl_o  <= 1'b0;
            sda_o  <= 1'b0;
            scl_oe <= 1'b0;
            sda_oe <= 1'b0;
        end else begin
            scl_o  <= 1'b0;
            sda_o  <= 1'b0;
            scl_oe <= nxt_scl_pull;
            sda_oe <= nxt_sda_pull;
        end
    end
endmodule // i2mt_top
`default_nettype wire
